// *** verilog/umd_decoder.sv ***
// Memory map decoder: routes fetch and data accesses of one 16-Mbyte space.
`timescale 1ns/1ps
`include "umd_defs.svh"
// Behaviour
// - One linear 16-Mbyte space: 256 segments of 64K, four 16K pages each.
// - With an external bus, reserved regions become external bus accesses.
// - Byte and word access everywhere; byte lanes come from access size and address bit 0.
// - Data memories and both register areas decode in segment 0.
// - Every instruction fetch goes to the program management unit.
// - Every data transfer goes to the data management unit.
// - Units cross the system bus for program memory, external and LXBus traffic.
// - System bus carries both directions between units at once.
// - Program SRAM has a sized write-protected part; writes there are blocked.
// - Top 256 bytes of dual-port RAM, and live register locations, are bit addressable.
// - Register bank maps 16 words; lower eight also as low and high bytes.
// - Each register area decodes 512 bytes of word registers.
// - Flash is one 64K and six 256K modules of 4K sectors.
// - 4K sector 15 of module 0 (C0'F000) is internal and closed to users.
// - Sectors erase alone, program in 128-byte blocks, protect by cluster.
// - Whole flash read-protectable; a password sequence unlocks it temporarily.
// - Flash reads fetch 128 bits and always use error correction.
// - Different flash modules can be served in parallel.
// - External IO area accesses disable pipeline optimizations for strict order.
// - External memory up to about 12 Mbytes reachable through its regions.
// - Data SRAM served by its own interface, apart from program path.
// - External and LXBus accesses are carried out by the external bus controller.
module umd_decoder
   import umd_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Device options
   input wire logic has_ext_bus,
   input wire logic [4:0] program_sram_wp_pages,
   input wire logic [6:0] flash_wp_mask,
   input wire logic read_prot_en,
   // Password entry
   input wire logic pw_valid,
   input wire logic [15:0] pw_word,
   input wire logic [15:0] pw_key0,
   input wire logic [15:0] pw_key1,
   input wire logic relock,
   // Access requests
   input umd_req_s fetch_req,
   input umd_req_s data_req,
   // Register bank lookup
   input wire logic gpr_valid,
   input wire logic [15:0] cp_base,
   input wire logic [3:0] gpr_idx,
   input wire logic gpr_byte,
   input wire logic gpr_hi,
   // Answers
   output umd_resp_s fetch_resp,
   output umd_resp_s data_resp,
   output logic [23:0] gpr_addr,
   output logic gpr_err,
   output logic gpr_done,
   output logic unlocked
);
   // ------------------------------------------------------------
   // Region decode
   // ------------------------------------------------------------
   umd_region_e fetch_rg;
   umd_region_e data_rg;
   // Two decoders so that fetch and data paths never wait on each other.
   umd_region u_fetch_rg (
      .addr(fetch_req.addr),
      .region(fetch_rg)
   );
   umd_region u_data_rg (
      .addr(data_req.addr),
      .region(data_rg)
   );

   // ------------------------------------------------------------
   // Password unlock
   // ------------------------------------------------------------
   umd_pw_e pw_r;
   umd_pw_e pw_nxt;
   always_comb begin
      pw_nxt = pw_r;
      if (relock) begin
         pw_nxt = PW_LOCKED;
      end else if (pw_valid) begin
         case (pw_r)
            PW_LOCKED: pw_nxt = (pw_word == pw_key0) ? PW_HALF : PW_LOCKED;
            PW_HALF: pw_nxt = (pw_word == pw_key1) ? PW_OPEN : PW_LOCKED;
            PW_OPEN: pw_nxt = PW_OPEN;
            default: pw_nxt = PW_LOCKED;
         endcase
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pw_r <= PW_LOCKED;
      end else begin
         pw_r <= pw_nxt;
      end
   end
   wire is_open = pw_r == PW_OPEN;
   assign unlocked = is_open;

   // ------------------------------------------------------------
   // Shared answer builder
   // ------------------------------------------------------------
   // Both ports use the same table; the fetch flag picks the home unit.
   function automatic umd_resp_s build(input umd_req_s q, input umd_region_e rg,
      input logic fetch, input logic ext_ok, input logic [4:0] wp_pages,
      input logic [6:0] wp_mask, input logic rd_lock, input logic [15:0] cp);
      umd_resp_s r;
      umd_unit_e tgt;
      logic sec_rsvd;
      logic wp_hit;
      logic [15:0] gpr_off;
      r = '0;
      tgt = UNIT_NONE;
      sec_rsvd = 1'b0;
      wp_hit = 1'b0;
      gpr_off = q.addr[15:0] - cp;
      case (rg)
         RG_FLASH, RG_PROGRAM_SRAM, RG_EMULATED_PROGRAM_SRAM: tgt = UNIT_PMU;
         RG_DATA_SRAM, RG_XBUS_FUNCTION_REGS, RG_EXTENDED_FUNCTION_REGS, RG_DUAL_PORT_RAM, RG_SFR, RG_IMB: tgt = UNIT_DMU;
         RG_EXT_MEM, RG_EXT_IO, RG_LXBUS: tgt = UNIT_EBC;
         RG_RSVD: tgt = ext_ok ? UNIT_EBC : UNIT_NONE;
         default: tgt = UNIT_NONE;
      endcase
      r.valid = q.valid;
      r.region = rg;
      r.unit = tgt;
      r.be = q.word ? 2'h3 : (q.addr[0] ? 2'h2 : 2'h1);
      // Anything outside the home unit crosses the system bus.
      r.sysbus = fetch ? (tgt != UNIT_PMU && tgt != UNIT_NONE)
         : (tgt == UNIT_PMU || tgt == UNIT_EBC);
      r.strict = rg == RG_EXT_IO;
      r.bit_ok = !fetch && ((rg == RG_DUAL_PORT_RAM && q.addr[15:8] == `UMD_DUAL_PORT_RAM_BIT_HI)
         || rg == RG_SFR || rg == RG_EXTENDED_FUNCTION_REGS
         || (rg == RG_DUAL_PORT_RAM && gpr_off < `UMD_GPR_BYTES));
      if (rg == RG_FLASH) begin
         r.fl_mod = q.addr[`UMD_FL_MOD_MSB:`UMD_FL_MOD_LSB];
         r.fl_sec = q.addr[`UMD_FL_SEC_MSB:`UMD_FL_SEC_LSB];
         r.fl_blk = q.addr[`UMD_FL_BLK_MSB:`UMD_FL_BLK_LSB];
         r.fl_line = q.addr[23:`UMD_FL_LINE_LSB];
         r.ecc_en = !q.write;
         sec_rsvd = r.fl_mod == 3'h0 && r.fl_sec == `UMD_FL_RSVD_SEC;
         wp_hit = q.write && wp_mask[r.fl_mod];
      end
      if (rg == RG_PROGRAM_SRAM && q.write) begin
         wp_hit = q.addr[16:12] < wp_pages;
      end
      // Blocked accesses carry no target, so the memory sees nothing.
      r.err = q.valid && (tgt == UNIT_NONE || sec_rsvd || wp_hit
         || (rg == RG_FLASH && !q.write && rd_lock));
      if (r.err) begin
         r.unit = UNIT_NONE;
         r.sysbus = 1'b0;
         r.ecc_en = 1'b0;
      end
      return r;
   endfunction

   umd_req_s fetch_q;
   always_comb begin
      fetch_q = fetch_req;
      fetch_q.write = 1'b0;
   end
   wire rd_lock = read_prot_en && !is_open;
   umd_resp_s fetch_nxt;
   umd_resp_s data_nxt;
   assign fetch_nxt = build(fetch_q, fetch_rg, 1'b1, has_ext_bus, program_sram_wp_pages,
      flash_wp_mask, rd_lock, cp_base);
   assign data_nxt = build(data_req, data_rg, 1'b0, has_ext_bus, program_sram_wp_pages,
      flash_wp_mask, rd_lock, cp_base);

   // ------------------------------------------------------------
   // Register bank address
   // ------------------------------------------------------------
   wire [15:0] gpr_word_off = {11'h000, gpr_idx, 1'b0};
   wire [15:0] gpr_byte_off = {11'h000, gpr_idx, gpr_hi};
   wire [15:0] gpr_loc = cp_base + (gpr_byte ? gpr_byte_off : gpr_word_off);
   // Byte names exist only for the lower eight registers.
   wire gpr_bad = (gpr_byte && gpr_idx[3]) || gpr_loc < `UMD_DUAL_PORT_RAM_LO
      || gpr_loc > `UMD_DUAL_PORT_RAM_HI;

   // ------------------------------------------------------------
   // Answer registers
   // ------------------------------------------------------------
   umd_resp_s fetch_r;
   umd_resp_s data_r;
   logic [23:0] gpr_addr_r;
   logic gpr_err_r;
   logic gpr_done_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fetch_r <= '0;
         data_r <= '0;
      end else begin
         fetch_r <= fetch_nxt;
         data_r <= data_nxt;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gpr_addr_r <= 24'h000000;
         gpr_err_r <= 1'b0;
         gpr_done_r <= 1'b0;
      end else begin
         gpr_done_r <= gpr_valid;
         if (gpr_valid) begin
            gpr_addr_r <= {8'h00, gpr_loc};
            gpr_err_r <= gpr_bad;
         end
      end
   end
   assign fetch_resp = fetch_r;
   assign data_resp = data_r;
   assign gpr_addr = gpr_addr_r;
   assign gpr_err = gpr_err_r;
   assign gpr_done = gpr_done_r;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_fetch_pmu;
      @(posedge core_clk) disable iff (rst)
      fetch_req.valid && fetch_req.addr[23:20] == 4'hc && !rd_lock
      && fetch_req.addr[23:12] != 12'hc0f |=> fetch_resp.unit == UNIT_PMU;
   endproperty
   a_fetch_pmu: assert property (p_fetch_pmu) else $error("flash fetch not sent to pmu");

   property p_data_sfr;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && data_req.addr[23:9] == 15'h007f
      |=> data_resp.region == RG_SFR && data_resp.unit == UNIT_DMU && data_resp.bit_ok;
   endproperty
   a_data_sfr: assert property (p_data_sfr) else $error("sfr area misdecoded");

   property p_rsvd_ebc;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && data_rg == RG_RSVD && has_ext_bus
      |=> data_resp.unit == UNIT_EBC && data_resp.sysbus && !data_resp.err;
   endproperty
   a_rsvd_ebc: assert property (p_rsvd_ebc) else $error("reserved access not forwarded");

   property p_byte_lane;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && !data_req.word |=> $onehot(data_resp.be)
      && data_resp.be[1] == $past(data_req.addr[0]);
   endproperty
   a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");

   property p_program_sram_wp;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && data_req.write && data_rg == RG_PROGRAM_SRAM
      && data_req.addr[16:12] < program_sram_wp_pages |=> data_resp.err && data_resp.unit == UNIT_NONE;
   endproperty
   a_program_sram_wp: assert property (p_program_sram_wp) else $error("protected program_sram write passed");

   property p_rsvd_sector;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && data_req.addr[23:12] == 12'hc0f |=> data_resp.err;
   endproperty
   a_rsvd_sector: assert property (p_rsvd_sector) else $error("internal sector reachable");

   property p_strict_io;
      @(posedge core_clk) disable iff (rst)
      data_req.valid ##1 data_resp.strict |-> $past(data_req.addr[23:16]) >= 8'h21
      && $past(data_req.addr[23:16]) <= 8'h3f;
   endproperty
   a_strict_io: assert property (p_strict_io) else $error("strict flag outside io area");

   property p_unlock;
      @(posedge core_clk) disable iff (rst)
      pw_valid && !relock && pw_r == PW_HALF && pw_word == pw_key1
      |=> unlocked && !$past(unlocked);
   endproperty
   a_unlock: assert property (p_unlock) else $error("password sequence did not unlock");

   property p_read_lock;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && !data_req.write && data_rg == RG_FLASH && read_prot_en && !unlocked
      |=> data_resp.err && !data_resp.ecc_en;
   endproperty
   a_read_lock: assert property (p_read_lock) else $error("locked flash read passed");

   property p_ecc;
      @(posedge core_clk) disable iff (rst)
      fetch_resp.valid && fetch_resp.region == RG_FLASH && !fetch_resp.err
      |-> fetch_resp.ecc_en && fetch_resp.fl_line == $past(fetch_req.addr[23:4]);
   endproperty
   a_ecc: assert property (p_ecc) else $error("flash read without 128-bit ecc line");

   property p_gpr_byte;
      @(posedge core_clk) disable iff (rst)
      gpr_valid && gpr_byte && gpr_idx[3] |=> gpr_done && gpr_err;
   endproperty
   a_gpr_byte: assert property (p_gpr_byte) else $error("byte name on upper register");

   property p_sysbus;
      @(posedge core_clk) disable iff (rst)
      data_resp.valid && data_resp.unit == UNIT_DMU |-> !data_resp.sysbus;
   endproperty
   a_sysbus: assert property (p_sysbus) else $error("local data access used system bus");

   property p_relock;
      @(posedge core_clk) disable iff (rst)
      relock |=> !unlocked;
   endproperty
   a_relock: assert property (p_relock) else $error("relock left flash unlocked");

   property p_flash_wp;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && data_req.write && data_rg == RG_FLASH
      && flash_wp_mask[data_req.addr[`UMD_FL_MOD_MSB:`UMD_FL_MOD_LSB]]
      |=> data_resp.err && data_resp.unit == UNIT_NONE;
   endproperty
   a_flash_wp: assert property (p_flash_wp) else $error("write to protected flash passed");

   property p_fetch_ext;
      @(posedge core_clk) disable iff (rst)
      fetch_req.valid && fetch_rg == RG_EXT_MEM
      |=> fetch_resp.unit == UNIT_EBC && fetch_resp.sysbus;
   endproperty
   a_fetch_ext: assert property (p_fetch_ext) else $error("external fetch not on system bus");

   property p_dual_bus;
      @(posedge core_clk) disable iff (rst)
      fetch_req.valid && fetch_rg == RG_EXT_MEM && data_req.valid && !data_req.write
      && data_rg == RG_PROGRAM_SRAM |=> fetch_resp.sysbus && data_resp.sysbus;
   endproperty
   a_dual_bus: assert property (p_dual_bus) else $error("system bus not two-way");

   property p_ext_mem;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && (data_req.addr[23:22] == 2'h1 || data_req.addr[23:22] == 2'h2)
      |=> data_resp.region == RG_EXT_MEM && data_resp.unit == UNIT_EBC;
   endproperty
   a_ext_mem: assert property (p_ext_mem) else $error("external memory area misrouted");

   property p_lxbus;
      @(posedge core_clk) disable iff (rst)
      data_req.valid && data_req.addr[23:14] == 10'h080
      |=> data_resp.region == RG_LXBUS && data_resp.unit == UNIT_EBC;
   endproperty
   a_lxbus: assert property (p_lxbus) else $error("lxbus access not sent to controller");
endmodule

// *** pkg/umd_defs.svh ***
// Address boundaries, field positions and protection constants of the memory map decoder.
`ifndef UMD_DEFS_SVH
`define UMD_DEFS_SVH
// 4-Kbyte page numbers, address bits 23 down to 12.
`define UMD_PG_IMB 12'hfff
`define UMD_PG_RSVD_TOP 12'hf00
`define UMD_PG_EMULATED_PROGRAM_SRAM_LO 12'he80
`define UMD_PG_EMULATED_PROGRAM_SRAM_HI 12'he9b
`define UMD_PG_PROGRAM_SRAM_LO 12'he00
`define UMD_PG_PROGRAM_SRAM_HI 12'he1b
`define UMD_PG_FLASH_LO 12'hc00
`define UMD_PG_FLASH_HI 12'hd8f
`define UMD_PG_EXT_LO 12'h400
`define UMD_PG_EXT_HI 12'hbff
`define UMD_PG_EXTIO_LO 12'h210
`define UMD_PG_EXTIO_HI 12'h3ff
`define UMD_PG_LX_LO 12'h200
`define UMD_PG_LX_HI 12'h20b
`define UMD_PG_LX_SPLIT 12'h206
`define UMD_PG_LX_GAP 12'h207
`define UMD_PG_DATA_SRAM_LO 12'h008
`define UMD_PG_DATA_SRAM_HI 12'h00d
`define UMD_PG_XBUS_FUNCTION_REGS 12'h00e
`define UMD_PG_SYS 12'h00f
// Bits 11 down to 8 of the topmost page that hold the 256-byte register window.
`define UMD_IMB_NIB 4'hf
// Bits 11 down to 9 of page 00F: 512-byte slices.
`define UMD_SL_EXTENDED_FUNCTION_REGS 3'h0
`define UMD_SL_DUAL_PORT_RAM_LO 3'h3
`define UMD_SL_DUAL_PORT_RAM_HI 3'h6
`define UMD_SL_SFR 3'h7
// Bits 15 down to 8 of the bit-addressable top of the dual-port RAM.
`define UMD_DUAL_PORT_RAM_BIT_HI 8'hfd
// Dual-port RAM word range inside segment 0.
`define UMD_DUAL_PORT_RAM_LO 16'hf600
`define UMD_DUAL_PORT_RAM_HI 16'hfdff
// Register bank: 16 words, 32 bytes.
`define UMD_GPR_BYTES 16'h0020
// Flash fields.
`define UMD_FL_MOD_MSB 20
`define UMD_FL_MOD_LSB 18
`define UMD_FL_SEC_MSB 17
`define UMD_FL_SEC_LSB 12
`define UMD_FL_BLK_MSB 11
`define UMD_FL_BLK_LSB 7
`define UMD_FL_LINE_LSB 4
// Reserved sector of module 0: module 0, sector 15 (C0'F000).
`define UMD_FL_RSVD_SEC 6'h0f
`define UMD_FL_MODS 7
`endif

// *** pkg/umd_pkg.sv ***
// Types shared by the memory map decoder modules.
package umd_pkg;
   typedef enum logic [3:0] {
      RG_EXT_MEM = 4'h0,
      RG_EXT_IO = 4'h1,
      RG_LXBUS = 4'h2,
      RG_RSVD = 4'h3,
      RG_FLASH = 4'h4,
      RG_PROGRAM_SRAM = 4'h5,
      RG_EMULATED_PROGRAM_SRAM = 4'h6,
      RG_DATA_SRAM = 4'h7,
      RG_XBUS_FUNCTION_REGS = 4'h8,
      RG_EXTENDED_FUNCTION_REGS = 4'h9,
      RG_DUAL_PORT_RAM = 4'ha,
      RG_SFR = 4'hb,
      RG_IMB = 4'hc
   } umd_region_e;
   typedef enum logic [1:0] {
      UNIT_PMU = 2'h0,
      UNIT_DMU = 2'h1,
      UNIT_EBC = 2'h2,
      UNIT_NONE = 2'h3
   } umd_unit_e;
   typedef enum logic [1:0] {
      PW_LOCKED = 2'h0,
      PW_HALF = 2'h1,
      PW_OPEN = 2'h2
   } umd_pw_e;
   typedef struct packed {
      logic valid;
      logic write;
      logic word;
      logic [23:0] addr;
   } umd_req_s;
   typedef struct packed {
      logic valid;
      umd_unit_e unit;
      umd_region_e region;
      logic [1:0] be;
      logic sysbus;
      logic strict;
      logic err;
      logic bit_ok;
      logic [2:0] fl_mod;
      logic [5:0] fl_sec;
      logic [4:0] fl_blk;
      logic [19:0] fl_line;
      logic ecc_en;
   } umd_resp_s;
endpackage

// *** verilog/umd_region.sv ***
// Fixed address comparison that names the region of one 24-bit address.
`timescale 1ns/1ps
`include "umd_defs.svh"
module umd_region
   import umd_pkg::*;
(
   // Address
   input wire logic [23:0] addr,
   // Region
   output umd_region_e region
);
   wire [11:0] pg = addr[23:12];
   wire [2:0] slice = addr[11:9];
   wire in_emulated_program_sram = pg >= `UMD_PG_EMULATED_PROGRAM_SRAM_LO && pg <= `UMD_PG_EMULATED_PROGRAM_SRAM_HI;
   wire in_program_sram = pg >= `UMD_PG_PROGRAM_SRAM_LO && pg <= `UMD_PG_PROGRAM_SRAM_HI;
   wire in_flash = pg >= `UMD_PG_FLASH_LO && pg <= `UMD_PG_FLASH_HI;
   wire in_ext = pg >= `UMD_PG_EXT_LO && pg <= `UMD_PG_EXT_HI;
   wire in_extio = pg >= `UMD_PG_EXTIO_LO && pg <= `UMD_PG_EXTIO_HI;
   wire in_lx = pg >= `UMD_PG_LX_LO && pg <= `UMD_PG_LX_HI && pg != `UMD_PG_LX_GAP
      && !(pg == `UMD_PG_LX_SPLIT && addr[11]);
   wire in_data_sram = pg >= `UMD_PG_DATA_SRAM_LO && pg <= `UMD_PG_DATA_SRAM_HI;
   wire in_low_ext = pg < `UMD_PG_DATA_SRAM_LO || (pg[11:4] != 8'h00 && pg < `UMD_PG_LX_LO);
   wire in_dual_port_ram = slice >= `UMD_SL_DUAL_PORT_RAM_LO && slice <= `UMD_SL_DUAL_PORT_RAM_HI;
   wire [3:0] sys_code = (slice == `UMD_SL_EXTENDED_FUNCTION_REGS) ? RG_EXTENDED_FUNCTION_REGS :
      (slice == `UMD_SL_SFR) ? RG_SFR : in_dual_port_ram ? RG_DUAL_PORT_RAM : RG_RSVD;
   // Every address falls into exactly one arm; mirrors and gaps are reserved.
   assign region = (pg == `UMD_PG_IMB && addr[11:8] == `UMD_IMB_NIB) ? RG_IMB :
      (pg >= `UMD_PG_RSVD_TOP) ? RG_RSVD :
      in_emulated_program_sram ? RG_EMULATED_PROGRAM_SRAM :
      in_program_sram ? RG_PROGRAM_SRAM :
      in_flash ? RG_FLASH :
      in_ext ? RG_EXT_MEM :
      in_extio ? RG_EXT_IO :
      in_lx ? RG_LXBUS :
      in_data_sram ? RG_DATA_SRAM :
      (pg == `UMD_PG_XBUS_FUNCTION_REGS) ? RG_XBUS_FUNCTION_REGS :
      (pg == `UMD_PG_SYS) ? umd_region_e'(sys_code) :
      in_low_ext ? RG_EXT_MEM : RG_RSVD;
endmodule

// *** dv/umd_cpu_model.sv ***
// Requester model of the fetch and data pipelines and of the password source.
`timescale 1ns/1ps
module umd_cpu_model
   import umd_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Requests
   output umd_req_s fetch_req,
   output umd_req_s data_req,
   // Password entry
   output logic pw_valid,
   output logic [15:0] pw_word
);
   initial begin
      fetch_req = '0;
      data_req = '0;
      pw_valid = 1'b0;
      pw_word = 16'h0000;
   end
   // Idle ports show the inverted address, so a stale value never looks like a request.
   task automatic release_all();
      fetch_req.valid = 1'b0;
      fetch_req.addr = ~fetch_req.addr;
      data_req.valid = 1'b0;
      data_req.addr = ~data_req.addr;
   endtask
   // Requests carry no write data; the unused port gets the same address and size with valid low.
   task automatic issue(input logic f, input logic w, input logic wd, input logic [23:0] a);
      @(negedge core_clk);
      fetch_req = '{f, 1'b0, wd, a};
      data_req = '{!f, w, wd, a};
      @(negedge core_clk);
      release_all();
   endtask
   task automatic issue2(input logic [23:0] af, input logic [23:0] ad);
      @(negedge core_clk);
      fetch_req = '{1'b1, 1'b0, 1'b1, af};
      data_req = '{1'b1, 1'b0, 1'b1, ad};
      @(negedge core_clk);
      release_all();
   endtask
   // One password word per pulse.
   task automatic enter_pw(input logic [15:0] w);
      @(negedge core_clk);
      pw_valid = 1'b1;
      pw_word = w;
      @(negedge core_clk);
      pw_valid = 1'b0;
      pw_word = ~w;
   endtask
endmodule

// *** dv/umd_decoder_bench.sv ***
// Self-checking testbench of the memory map decoder.
`timescale 1ns/1ps
module unified_memory_map_decoder_bench
   import umd_pkg::*;
;
   logic core_clk, rst, has_ext_bus, read_prot_en, relock;
   logic gpr_valid, gpr_byte, gpr_hi, pw_valid, gpr_err, gpr_done, unlocked;
   logic [4:0] program_sram_wp_pages;
   logic [6:0] flash_wp_mask;
   logic [15:0] pw_key0, pw_key1, cp_base, pw_word;
   logic [3:0] gpr_idx;
   logic [23:0] gpr_addr;
   umd_req_s fetch_req, data_req;
   umd_resp_s fetch_resp, data_resp, last_r;
   int error_cnt, samples_checked;

   umd_cpu_model cpu (.core_clk(core_clk), .fetch_req(fetch_req), .data_req(data_req),
      .pw_valid(pw_valid), .pw_word(pw_word));
   umd_decoder DUT (.core_clk(core_clk), .rst(rst), .has_ext_bus(has_ext_bus),
      .program_sram_wp_pages(program_sram_wp_pages), .flash_wp_mask(flash_wp_mask),
      .read_prot_en(read_prot_en), .pw_valid(pw_valid), .pw_word(pw_word),
      .pw_key0(pw_key0), .pw_key1(pw_key1), .relock(relock), .fetch_req(fetch_req),
      .data_req(data_req), .gpr_valid(gpr_valid), .cp_base(cp_base), .gpr_idx(gpr_idx),
      .gpr_byte(gpr_byte), .gpr_hi(gpr_hi), .fetch_resp(fetch_resp),
      .data_resp(data_resp), .gpr_addr(gpr_addr), .gpr_err(gpr_err),
      .gpr_done(gpr_done), .unlocked(unlocked));

   always #25 core_clk = ~core_clk;

   task automatic tally_and_finish();
      $display("mismatches=%0d comparisons=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask

   // Expected routing is rebuilt here from the target unit, never read back from the design.
   task automatic acc(input logic f, input logic w, input logic wd, input logic [23:0] a,
      input umd_region_e rg, input umd_unit_e u, input logic e);
      logic sb;
      cpu.issue(f, w, wd, a);
      last_r = f ? fetch_resp : data_resp;
      sb = e ? 1'b0 : (f ? (u != UNIT_PMU) : (u != UNIT_DMU));
      chk(last_r.valid, 1'b1);
      chk(last_r.region, rg);
      chk(last_r.unit, e ? UNIT_NONE : u);
      chk(last_r.err, e);
      chk(last_r.sysbus, sb);
      chk(last_r.be, wd ? 2'h3 : (a[0] ? 2'h2 : 2'h1));
      chk(last_r.strict, rg == RG_EXT_IO);
      chk(last_r.ecc_en, rg == RG_FLASH && !w && !e);
   endtask

   task automatic t_map();
      acc(0, 0, 1, 24'h000000, RG_EXT_MEM, UNIT_EBC, 0);
      acc(0, 0, 0, 24'h008001, RG_DATA_SRAM, UNIT_DMU, 0);
      acc(0, 0, 1, 24'h00dffe, RG_DATA_SRAM, UNIT_DMU, 0);
      acc(0, 0, 1, 24'h00e000, RG_XBUS_FUNCTION_REGS, UNIT_DMU, 0);
      acc(0, 0, 1, 24'h00f000, RG_EXTENDED_FUNCTION_REGS, UNIT_DMU, 0);
      chk(last_r.bit_ok, 1'b1);
      acc(0, 0, 1, 24'h00f200, RG_RSVD, UNIT_EBC, 0);
      acc(0, 0, 1, 24'h00f600, RG_DUAL_PORT_RAM, UNIT_DMU, 0);
      acc(0, 0, 0, 24'h00fe10, RG_SFR, UNIT_DMU, 0);
      acc(0, 1, 1, 24'h010000, RG_EXT_MEM, UNIT_EBC, 0);
      acc(0, 0, 1, 24'h200000, RG_LXBUS, UNIT_EBC, 0);
      acc(0, 1, 1, 24'h206800, RG_RSVD, UNIT_EBC, 0);
      acc(0, 0, 1, 24'h207000, RG_RSVD, UNIT_EBC, 0);
      acc(0, 0, 1, 24'h210000, RG_EXT_IO, UNIT_EBC, 0);
      acc(0, 1, 0, 24'h3fffff, RG_EXT_IO, UNIT_EBC, 0);
      acc(0, 0, 1, 24'hbffffe, RG_EXT_MEM, UNIT_EBC, 0);
      acc(0, 0, 1, 24'hc00000, RG_FLASH, UNIT_PMU, 0);
      acc(0, 1, 1, 24'he00000, RG_PROGRAM_SRAM, UNIT_PMU, 0);
      acc(0, 0, 1, 24'he80000, RG_EMULATED_PROGRAM_SRAM, UNIT_PMU, 0);
      acc(0, 0, 1, 24'hf00000, RG_RSVD, UNIT_EBC, 0);
      acc(0, 0, 1, 24'hffff00, RG_IMB, UNIT_DMU, 0);
      acc(1, 0, 1, 24'he00000, RG_PROGRAM_SRAM, UNIT_PMU, 0);
      acc(1, 0, 1, 24'h400000, RG_EXT_MEM, UNIT_EBC, 0);
      acc(1, 0, 1, 24'hd80000, RG_FLASH, UNIT_PMU, 0);
   endtask

   task automatic t_rsvd_nobus();
      has_ext_bus = 1'b0;
      acc(0, 0, 1, 24'hf00000, RG_RSVD, UNIT_NONE, 1);
      acc(1, 0, 1, 24'h00f200, RG_RSVD, UNIT_NONE, 1);
      has_ext_bus = 1'b1;
   endtask

   task automatic t_flash();
      acc(0, 0, 1, 24'hd43080, RG_FLASH, UNIT_PMU, 0);
      chk(last_r.fl_mod, 3'h5);
      chk(last_r.fl_sec, 6'h03);
      chk(last_r.fl_blk, 5'h01);
      chk(last_r.fl_line, 20'hd4308);
      acc(0, 0, 1, 24'hd8f000, RG_FLASH, UNIT_PMU, 0);
      chk(last_r.fl_mod, 3'h6);
   endtask

   task automatic t_prot();
      program_sram_wp_pages = 5'h02;
      flash_wp_mask = 7'h20;
      acc(0, 1, 1, 24'he01ffe, RG_PROGRAM_SRAM, UNIT_PMU, 1);
      acc(0, 1, 1, 24'he02000, RG_PROGRAM_SRAM, UNIT_PMU, 0);
      acc(0, 0, 1, 24'he00000, RG_PROGRAM_SRAM, UNIT_PMU, 0);
      acc(0, 1, 1, 24'hd40000, RG_FLASH, UNIT_PMU, 1);
      acc(0, 1, 1, 24'hd00000, RG_FLASH, UNIT_PMU, 0);
      acc(0, 0, 1, 24'hc0f000, RG_FLASH, UNIT_PMU, 1);
      acc(1, 0, 1, 24'hc0fffe, RG_FLASH, UNIT_PMU, 1);
      acc(0, 0, 1, 24'hc0effe, RG_FLASH, UNIT_PMU, 0);
      program_sram_wp_pages = 5'h00;
      flash_wp_mask = 7'h00;
   endtask

   task automatic t_pw();
      read_prot_en = 1'b1;
      acc(0, 0, 1, 24'hc40000, RG_FLASH, UNIT_PMU, 1);
      cpu.enter_pw(pw_key0);
      cpu.enter_pw(16'h0001);
      cpu.enter_pw(pw_key1);
      @(negedge core_clk);
      chk(unlocked, 1'b0);
      cpu.enter_pw(pw_key0);
      cpu.enter_pw(pw_key1);
      @(negedge core_clk);
      chk(unlocked, 1'b1);
      acc(1, 0, 1, 24'hc40000, RG_FLASH, UNIT_PMU, 0);
      relock = 1'b1;
      @(negedge core_clk);
      relock = 1'b0;
      @(negedge core_clk);
      chk(unlocked, 1'b0);
      acc(0, 0, 1, 24'hc40000, RG_FLASH, UNIT_PMU, 1);
      read_prot_en = 1'b0;
   endtask

   task automatic t_bit();
      cp_base = 16'hf600;
      acc(0, 0, 0, 24'h00fd00, RG_DUAL_PORT_RAM, UNIT_DMU, 0);
      chk(last_r.bit_ok, 1'b1);
      acc(0, 0, 1, 24'h00f61e, RG_DUAL_PORT_RAM, UNIT_DMU, 0);
      chk(last_r.bit_ok, 1'b1);
      acc(0, 0, 1, 24'h00f620, RG_DUAL_PORT_RAM, UNIT_DMU, 0);
      chk(last_r.bit_ok, 1'b0);
      acc(0, 0, 1, 24'h008000, RG_DATA_SRAM, UNIT_DMU, 0);
      chk(last_r.bit_ok, 1'b0);
   endtask

   task automatic general_purpose_reg(input logic [3:0] i, input logic b, input logic h,
      input logic [23:0] ea, input logic ee);
      int n;
      @(negedge core_clk);
      gpr_idx = i;
      gpr_byte = b;
      gpr_hi = h;
      gpr_valid = 1'b1;
      @(negedge core_clk);
      gpr_valid = 1'b0;
      n = 0;
      while (gpr_done !== 1'b1 && n < 4) begin
         @(negedge core_clk);
         n++;
      end
      if (gpr_done !== 1'b1) begin
         error_cnt++;
         tally_and_finish();
      end else begin
         chk(gpr_addr, ea);
         chk(gpr_err, ee);
      end
   endtask

   task automatic t_gpr();
      cp_base = 16'hf800;
      general_purpose_reg(4'h3, 0, 0, 24'h00f806, 0);
      general_purpose_reg(4'hf, 0, 0, 24'h00f81e, 0);
      general_purpose_reg(4'h2, 1, 1, 24'h00f805, 0);
      general_purpose_reg(4'h8, 1, 0, 24'h00f810, 1);
      cp_base = 16'hfdf0;
      general_purpose_reg(4'hf, 0, 0, 24'h00fe0e, 1);
   endtask

   // Both ports in one cycle: to two flash modules, then to external memory and program SRAM.
   task automatic t_dual();
      cpu.issue2(24'hc00000, 24'hcc0000);
      chk(fetch_resp.valid, 1'b1);
      chk(data_resp.valid, 1'b1);
      chk(fetch_resp.fl_mod, 3'h0);
      chk(data_resp.fl_mod, 3'h3);
      chk(fetch_resp.sysbus, 1'b0);
      chk(data_resp.sysbus, 1'b1);
      cpu.issue2(24'h400000, 24'he00000);
      chk(fetch_resp.unit, UNIT_EBC);
      chk(data_resp.unit, UNIT_PMU);
      chk(fetch_resp.sysbus, 1'b1);
      chk(data_resp.sysbus, 1'b1);
   endtask

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      has_ext_bus = 1'b1;
      program_sram_wp_pages = 5'h00;
      flash_wp_mask = 7'h00;
      read_prot_en = 1'b0;
      relock = 1'b0;
      pw_key0 = 16'h5a3c;
      pw_key1 = 16'hc3a5;
      gpr_valid = 1'b0;
      cp_base = 16'h0000;
      gpr_idx = 4'h0;
      gpr_byte = 1'b0;
      gpr_hi = 1'b0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_map();
      t_rsvd_nobus();
      t_flash();
      t_prot();
      t_pw();
      t_bit();
      t_gpr();
      t_dual();
      tally_and_finish();
   end
endmodule
